// ---- common/cdr_map.vh ----
`ifndef CDR_MAP_VH
`define CDR_MAP_VH

// Register addresses (byte addresses on the register port)
`define CDR_LVL0_ADDR      32'h40086800
`define CDR_CTRL0_ADDR     32'h40086804
`define CDR_LVL1_ADDR      32'h40086808
`define CDR_CTRL1_ADDR     32'h4008680c
`define CDR_CH_STRIDE      32'h00000008

// Level register fields
`define CDR_COARSE_MSB     27
`define CDR_COARSE_LSB     17
`define CDR_FINE_MSB       16
`define CDR_FINE_LSB       12
`define CDR_CODE_MSB       27
`define CDR_CODE_LSB       12
`define CDR_HOLD_LSB       0
`define CDR_HOLD_BITS      4
`define CDR_LVL_WMASK      32'h0ffff00f
`define CDR_LVL_RESET      32'h00000000

// Control register fields
`define CDR_UNLOCK_BIT     7
`define CDR_CUTOFF_BIT     6
`define CDR_FILTER_MSB     5
`define CDR_FILTER_LSB     2
`define CDR_SINK_BIT       1
`define CDR_PWROFF_BIT     0
`define CDR_CTRL_RESET     8'h01

// Register port answer latency in clk_sys cycles
`define CDR_ACK_CYCLES     1

`endif

// ---- hdl/cdr_hold_ch2.v ----
`timescale 1ns/1ps

// Two-stage synchroniser for a level arriving from outside the clock domain
module cdr_hold_ch2 (
    clk,
    rst_n,
    async_in,
    sync_out
);
    input  wire clk;       // System clock
    input  wire rst_n;     // Active-low reset, already synchronised
    input  wire async_in;  // Level from another domain
    output reg  sync_out;  // Safe copy, two flops late

    reg meta_reg;          // First stage, read only by the second

    // Metastability filter; nothing but sync_out looks at meta_reg
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // cdr_hold_ch2

// ---- hdl/cdr_channel.v ----
`timescale 1ns/1ps

// Output stage of one channel: update hold and thermal cutoff
module cdr_channel (
    clk,
    rst_n,
    level_code,
    hold,
    cutoff,
    coarse_code,
    fine_code
);
    input  wire        clk;          // System clock
    input  wire        rst_n;        // Active-low synchronised reset
    input  wire [15:0] level_code;   // Coarse and fine fields of level reg
    input  wire        hold;         // Update held by every channel
    input  wire        cutoff;       // Thermal cutoff active
    output reg  [10:0] coarse_code;  // Coarse code to the DAC core
    output reg  [4:0]  fine_code;    // Fine code to the DAC core

    reg [15:0] applied_reg;          // Last code passed through
    reg [15:0] applied_next;         // Next applied code
    reg [15:0] out_next;             // Next value seen by the core

    // Applied code follows the level field unless held
    always @* begin
        if (hold) begin
            applied_next = applied_reg;
        end else begin
            applied_next = level_code;
        end
        // Cutoff only masks the core; the applied code survives it
        if (cutoff) begin
            out_next = 16'h0000;
        end else begin
            out_next = applied_next;
        end
    end

    // Applied code and core outputs, zero from reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            applied_reg <= 16'h0000;
            coarse_code <= 11'h000;
            fine_code   <= 5'h00;
        end else begin
            applied_reg <= applied_next;
            coarse_code <= out_next[15:5];
            fine_code   <= out_next[4:0];
        end
    end
endmodule // cdr_channel

// ---- hdl/cdr_top.v ----
`timescale 1ns/1ps
`include "cdr_map.vh"

// Contract
// - All hold bits for n set: hold output n
// - Any hold bit n clear: write applies immediately
// - Coarse 27:17, fine 16:12 drive core
// - Unlock bit 7 gates writes; zero clears level
// - Bit 6 enables overtemperature forced zero current
// - Bits 5:2 select output filter resistor
// - Bit 1 enables sink, resets zero
// - Bit 0 powers down, resets one
// - Level registers reset to all zeros
// - Control registers reset to 0x01
module cdr_top #(
    parameter NUM_CH = 2            // Channels in this bank, at most four
) (
    clk_sys,
    reset_n,
    reg_addr,
    reg_wr,
    reg_rd,
    reg_wdata,
    reg_rdata,
    reg_ack,
    reg_err,
    overtemp,
    coarse_code,
    fine_code,
    filter_select,
    sink_enable,
    power_off
);
    // Clock and reset
    input  wire                  clk_sys;        // 250 MHz system clock
    input  wire                  reset_n;        // Asynchronous active-low reset
    // Register port
    input  wire [31:0]           reg_addr;       // Byte address
    input  wire                  reg_wr;         // Write request, one cycle
    input  wire                  reg_rd;         // Read request, one cycle
    input  wire [31:0]           reg_wdata;      // Write data
    output reg  [31:0]           reg_rdata;      // Read data, valid with ack
    output reg                   reg_ack;        // Answer pulse
    output reg                   reg_err;        // Unmapped address, with ack
    // Thermal indication from the sensor comparator
    input  wire                  overtemp;       // Asynchronous level
    // Analog core controls, channel 0 in the low slice
    output wire [11*NUM_CH-1:0]  coarse_code;    // Coarse codes
    output wire [5*NUM_CH-1:0]   fine_code;      // Fine codes
    output wire [4*NUM_CH-1:0]   filter_select;  // Filter resistor selects
    output wire [NUM_CH-1:0]     sink_enable;    // Pull-down sink enables
    output wire [NUM_CH-1:0]     power_off;      // Power-down controls

    // Reset release synchroniser
    reg        rst_meta_reg;                     // First stage
    reg        rst_n_sync;                       // Design-wide reset copy

    // Register storage, flattened per channel
    wire [32*NUM_CH-1:0]     lvl_flat;           // Level registers
    wire [8*NUM_CH-1:0]      ctrl_flat;          // Control registers
    wire [NUM_CH-1:0]        lvl_hit;            // Address selects a level reg
    wire [NUM_CH-1:0]        ctrl_hit;           // Address selects a control reg
    wire [NUM_CH-1:0]        hold;               // Effective hold per channel
    wire [NUM_CH-1:0]        cutoff;             // Forced zero per channel
    wire [NUM_CH*NUM_CH-1:0] hold_bits;          // Hold bit n of every channel
    wire                     overtemp_sync;      // Synchronised thermal level

    // Bus answer path
    reg  [31:0]              rdata_next;         // Next read data
    reg                      err_next;           // Next error flag
    wire                     any_hit;            // Some register addressed
    wire                     req;                // Read or write request

    integer                  k;                  // Read mux index

    // Async assert, clocked release: only the first flop takes a constant, the second copies it
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_sync   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_sync   <= rst_meta_reg;
        end
    end

    // The comparator output is not timed to clk_sys
    cdr_hold_ch2 u_ot_sync (
        .clk      (clk_sys),
        .rst_n    (rst_n_sync),
        .async_in (overtemp),
        .sync_out (overtemp_sync)
    );

    assign req     = reg_wr | reg_rd;
    assign any_hit = (|lvl_hit) | (|ctrl_hit);

    // Per-channel registers, decode and output stage
    genvar i;
    genvar n;
    generate
        for (i = 0; i < NUM_CH; i = i + 1) begin : g_ch
            // Addresses of this channel's pair
            localparam [31:0] LVL_A  = `CDR_LVL0_ADDR + i * `CDR_CH_STRIDE;
            localparam [31:0] CTRL_A = `CDR_CTRL0_ADDR + i * `CDR_CH_STRIDE;

            reg  [31:0] lvl_reg;                  // Level register
            reg  [31:0] lvl_next;                 // Next level value
            reg  [7:0]  ctrl_reg;                 // Control register
            reg  [7:0]  ctrl_next;                // Next control value
            reg  [3:0]  filter_reg;               // Filter select copy for pins
            reg         sink_reg;                 // Sink enable copy for pins
            reg         pwroff_reg;               // Power-down copy for pins

            assign lvl_hit[i]  = (reg_addr == LVL_A);
            assign ctrl_hit[i] = (reg_addr == CTRL_A);

            // Control register; every bit is plain read/write
            always @* begin
                ctrl_next = ctrl_reg;
                if (reg_wr && ctrl_hit[i]) begin
                    ctrl_next = reg_wdata[7:0];
                end
            end

            // Level register: unlocked writes only, else forced clear
            always @* begin
                lvl_next = lvl_reg;
                if (!ctrl_reg[`CDR_UNLOCK_BIT]) begin
                    lvl_next = `CDR_LVL_RESET;
                end else if (reg_wr && lvl_hit[i]) begin
                    // Reserved bits are dropped and read back as zero
                    lvl_next = reg_wdata & `CDR_LVL_WMASK;
                end
            end

            // Storage and pin copies, defined from reset
            always @(posedge clk_sys or negedge rst_n_sync) begin
                if (!rst_n_sync) begin
                    lvl_reg    <= `CDR_LVL_RESET;
                    ctrl_reg   <= `CDR_CTRL_RESET;
                    filter_reg <= 4'h0;
                    sink_reg   <= 1'b0;
                    pwroff_reg <= 1'b1;
                end else begin
                    lvl_reg    <= lvl_next;
                    ctrl_reg   <= ctrl_next;
                    // Pin copies track the written value in the same edge
                    filter_reg <= ctrl_next[`CDR_FILTER_MSB:`CDR_FILTER_LSB];
                    sink_reg   <= ctrl_next[`CDR_SINK_BIT];
                    pwroff_reg <= ctrl_next[`CDR_PWROFF_BIT];
                end
            end

            assign lvl_flat[32*i +: 32] = lvl_reg;
            assign ctrl_flat[8*i +: 8]  = ctrl_reg;

            // Hold bit n of channel i, as seen by channel n, lands in slot n*NUM_CH+i
            for (n = 0; n < NUM_CH; n = n + 1) begin : g_hold
                assign hold_bits[n*NUM_CH + i] = lvl_reg[`CDR_HOLD_LSB + n];
            end

            // Held only when every channel agrees
            assign hold[i] = &hold_bits[i*NUM_CH +: NUM_CH];

            // Cutoff needs both the enable and the live indication
            assign cutoff[i] = ctrl_reg[`CDR_CUTOFF_BIT] & overtemp_sync;

            cdr_channel u_chan (
                .clk         (clk_sys),
                .rst_n       (rst_n_sync),
                .level_code  (lvl_reg[`CDR_CODE_MSB:`CDR_CODE_LSB]),
                .hold        (hold[i]),
                .cutoff      (cutoff[i]),
                .coarse_code (coarse_code[11*i +: 11]),
                .fine_code   (fine_code[5*i +: 5])
            );

            assign filter_select[4*i +: 4] = filter_reg;
            assign sink_enable[i]          = sink_reg;
            assign power_off[i]            = pwroff_reg;
        end
    endgenerate

    // Read mux; unmapped addresses answer zero with the error flag
    always @* begin
        rdata_next = 32'h00000000;
        err_next   = 1'b0;
        for (k = 0; k < NUM_CH; k = k + 1) begin
            if (lvl_hit[k]) begin
                rdata_next = lvl_flat[32*k +: 32];
            end
            if (ctrl_hit[k]) begin
                rdata_next = {24'h000000, ctrl_flat[8*k +: 8]};
            end
        end
        if (!reg_rd) begin
            // Writes return no data
            rdata_next = 32'h00000000;
        end
        if (req && !any_hit) begin
            err_next = 1'b1;
        end
    end

    // Answer one cycle after the request; read shows pre-write contents
    always @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            reg_rdata <= 32'h00000000;
            reg_ack   <= 1'b0;
            reg_err   <= 1'b0;
        end else begin
            reg_rdata <= rdata_next;
            reg_ack   <= req;
            reg_err   <= err_next;
        end
    end
endmodule // cdr_top

// ---- sim/cdr_top_properties.sv ----
`timescale 1ns/1ps
`include "cdr_map.vh"

// Ties the register port to the DAC pins of cdr_top
module cdr_top_properties #(parameter NUM_CH = 2) (
    input wire logic                 clk_sys, reset_n, reg_wr, reg_rd, reg_ack, reg_err, overtemp,
    input wire logic [31:0]          reg_addr, reg_wdata, reg_rdata,
    input wire logic [11*NUM_CH-1:0] coarse_code,
    input wire logic [5*NUM_CH-1:0]  fine_code,
    input wire logic [4*NUM_CH-1:0]  filter_select,
    input wire logic [NUM_CH-1:0]    sink_enable, power_off
);
    reg [31:0] wd1_reg, wd2_reg;     // Write data one and two cycles back
    reg        cut0_reg, unl0_reg;   // Channel 0 cutoff and unlock as written
    wire       ctl0_wr = reg_wr && reg_addr == `CDR_CTRL0_ADDR;  // Control 0 write
    wire       ctl1_wr = reg_wr && reg_addr == `CDR_CTRL1_ADDR;  // Control 1 write

    // Delay line instead of $past on slices, which some tools reject
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wd1_reg  <= 32'h0;
            wd2_reg  <= 32'h0;
            cut0_reg <= 1'b0;
            unl0_reg <= 1'b0;
        end else begin
            wd1_reg <= reg_wdata;
            wd2_reg <= wd1_reg;
            if (ctl0_wr) begin
                cut0_reg <= reg_wdata[6];
                unl0_reg <= reg_wdata[7];
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Unheld, unlocked level write to channel 0
    sequence s_lvl0_wr;
        reg_wr && reg_addr == `CDR_LVL0_ADDR && !reg_wdata[0] && unl0_reg && !cut0_reg;
    endsequence
    // Overtemperature long enough to pass the synchroniser
    sequence s_hot0;
        (overtemp && cut0_reg)[*4];
    endsequence

    property p_rst_power; $rose(reset_n) |-> &power_off; endproperty
    property p_rst_sink; $rose(reset_n) |-> sink_enable == '0; endproperty
    property p_rst_code; $rose(reset_n) |-> coarse_code == '0 && fine_code == '0; endproperty
    property p_rst_filter; $rose(reset_n) |-> filter_select == '0; endproperty
    property p_wr_filter; ctl1_wr |=> filter_select[7:4] == wd1_reg[5:2]; endproperty
    property p_wr_sink; ctl0_wr |=> sink_enable[0] == wd1_reg[1]; endproperty
    property p_wr_power; ctl1_wr |=> power_off[1] == wd1_reg[0]; endproperty
    property p_lvl_apply;
        s_lvl0_wr |=> ##1 coarse_code[10:0] == wd2_reg[27:17] && fine_code[4:0] == wd2_reg[16:12];
    endproperty
    property p_cutoff; s_hot0 |-> coarse_code[10:0] == 11'h0 && fine_code[4:0] == 5'h0; endproperty

    a_rst_power: assert property (p_rst_power) else $error("power off not set after reset");
    a_rst_sink: assert property (p_rst_sink) else $error("sink on after reset");
    a_rst_code: assert property (p_rst_code) else $error("codes not zero after reset");
    a_rst_filter: assert property (p_rst_filter) else $error("filter not zero after reset");
    a_wr_filter: assert property (p_wr_filter) else $error("filter select not written");
    a_wr_sink: assert property (p_wr_sink) else $error("sink enable not written");
    a_wr_power: assert property (p_wr_power) else $error("power off not written");
    a_lvl_apply: assert property (p_lvl_apply) else $error("level not applied");
    a_cutoff: assert property (p_cutoff) else $error("cutoff did not zero codes");
endmodule // cdr_top_properties

bind cdr_top cdr_top_properties #(.NUM_CH(NUM_CH)) u_props (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_ack(reg_ack), .reg_err(reg_err), .overtemp(overtemp),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .coarse_code(coarse_code),
    .fine_code(fine_code), .filter_select(filter_select), .sink_enable(sink_enable), .power_off(power_off));

// ---- sim/current_dac_channel_regs_tb.sv ----
`timescale 1ns/1ps
`include "cdr_map.vh"

`define CHECK(nm, ex, gt) begin comparisons++; if ((ex) !== (gt)) begin bad_count++; \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); end end

// Random and corner traffic with a shadow model of both channels
module current_dac_channel_regs_tb;
    logic        clk_sys, reset_n, reg_wr, reg_rd, overtemp, hot;  // Drives and cutoff model
    logic [31:0] reg_addr, reg_wdata, reg_rdata, seed, got, r;    // Port and scratch
    logic        reg_ack, reg_err;                                  // Answer
    logic [21:0] coarse_code;                                       // Coarse codes
    logic [9:0]  fine_code;                                         // Fine codes
    logic [7:0]  filter_select;                                     // Filter selects
    logic [1:0]  sink_enable, power_off;                            // Sink and power pins
    logic [31:0] lvl [2];                                           // Level model
    logic [7:0]  ctl [2];                                           // Control model
    logic [15:0] app [2];                                           // Applied code model
    int          bad_count, comparisons;                            // Tallies

    cdr_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .reg_err(reg_err), .overtemp(overtemp), .coarse_code(coarse_code), .fine_code(fine_code),
        .filter_select(filter_select), .sink_enable(sink_enable), .power_off(power_off));

    // Repeatable xorshift source
    function automatic logic [31:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected read value of a mapped address
    function automatic logic [31:0] exp_rd(input logic [31:0] a);
        return a[2] ? {24'h0, ctl[a[3]]} : lvl[a[3]];
    endfunction

    // One request at a falling edge; answer is due one cycle later, then one idle cycle
    task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        @(negedge clk_sys);
        q = reg_rdata;
        `CHECK("ack", 1'b1, reg_ack)
        `CHECK("err", (a & ~32'hc) != `CDR_LVL0_ADDR, reg_err)
        // Request drops here, so a following call raises it at a later edge
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        @(negedge clk_sys);
        `CHECK("ack end", 1'b0, reg_ack)
    endtask

    // Compare every pin with the model; hold is recomputed from the stored bits
    task automatic check_pins();
        for (int n = 0; n < 2; n++) begin
            if (!(lvl[0][n] & lvl[1][n])) app[n] = lvl[n][27:12];
            `CHECK("coarse", (hot && ctl[n][6]) ? 11'h0 : app[n][15:5], coarse_code[11*n +: 11])
            `CHECK("fine", (hot && ctl[n][6]) ? 5'h0 : app[n][4:0], fine_code[5*n +: 5])
            `CHECK("filter", ctl[n][5:2], filter_select[4*n +: 4])
            `CHECK("sink", ctl[n][1], sink_enable[n])
            `CHECK("power", ctl[n][0], power_off[n])
        end
    endtask

    // Write, update the model, wait out the unlock clear path, check pins
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        access(1'b1, a, d, got);
        if (a[2]) ctl[a[3]] = d[7:0];
        else if (ctl[a[3]][7]) lvl[a[3]] = d & `CDR_LVL_WMASK;
        if (!ctl[a[3]][7]) lvl[a[3]] = 32'h0;
        repeat (2) @(negedge clk_sys);
        check_pins();
    endtask

    // Read back and compare against the model
    task automatic rd_chk(input logic [31:0] a);
        access(1'b0, a, 32'h0, got);
        `CHECK("rdata", exp_rd(a), got)
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Main sequence
    initial begin
        {reset_n, reg_wr, reg_rd, overtemp, hot, reg_addr, reg_wdata} = '0;
        {bad_count, comparisons} = '0;
        seed = 32'h8555a378;
        lvl = '{32'h0, 32'h0};
        ctl = '{8'h01, 8'h01};
        app = '{16'h0, 16'h0};
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        check_pins();
        for (int i = 0; i < 4; i++) begin
            access(1'b0, `CDR_LVL0_ADDR + 4 * i, 32'h0, got);
            `CHECK("reset value", exp_rd(`CDR_LVL0_ADDR + 4 * i), got)
        end
        // Unmapped place: write dropped, read zero with error
        wr_reg(32'h40086810, 32'hffffffff);
        access(1'b0, 32'h40086810, 32'h0, got);
        `CHECK("unmapped", 32'h0, got)
        // Random control and level traffic, often locked, hold bits random
        for (int i = 0; i < 60; i++) begin
            r = nxt();
            if (r[1]) wr_reg(`CDR_CTRL0_ADDR + 8 * r[0], {24'h0, |r[9:8], 1'b0, r[7:2]});
            else wr_reg(`CDR_LVL0_ADDR + 8 * r[0], nxt());
            rd_chk(`CDR_LVL0_ADDR + 4 * r[1:0]);
        end
        // Hold bit 0 set in both level registers, holding channel 0, then released by channel 1
        wr_reg(`CDR_CTRL0_ADDR, 32'h80);
        wr_reg(`CDR_CTRL1_ADDR, 32'h80);
        wr_reg(`CDR_LVL1_ADDR, 32'h1);
        wr_reg(`CDR_LVL0_ADDR, 32'h0aaaa001);
        wr_reg(`CDR_LVL1_ADDR, 32'h0);
        // Lock clears the level register
        wr_reg(`CDR_CTRL0_ADDR, 32'h00);
        rd_chk(`CDR_LVL0_ADDR);
        // Thermal cutoff forces zero, then the code returns
        wr_reg(`CDR_CTRL0_ADDR, 32'hc0);
        wr_reg(`CDR_LVL0_ADDR, 32'h05555000);
        {overtemp, hot} = 2'b11;
        repeat (4) @(negedge clk_sys);
        check_pins();
        {overtemp, hot} = 2'b00;
        repeat (4) @(negedge clk_sys);
        check_pins();
        complete_run();
    end
endmodule // current_dac_channel_regs_tb
